// file: verilog/bst_pkg.sv
// shared constants, types and chain decode for the boundary-scan test port
package bst_pkg;

    // ------------------------------------------------------------
    // chain and register sizes
    // ------------------------------------------------------------
    localparam int IR_W      = 3;
    localparam int BS_W      = 98;
    localparam int ID_W      = 32;
    localparam int TLR_ONES  = 5;

    // ------------------------------------------------------------
    // instruction codes
    // ------------------------------------------------------------
    localparam logic [IR_W-1:0] IR_EXTEST  = 3'h0;
    localparam logic [IR_W-1:0] IR_SAMPLE  = 3'h4;
    localparam logic [IR_W-1:0] IR_IDCODE  = 3'h6;
    localparam logic [IR_W-1:0] IR_BYPASS  = 3'h7;
    localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;

    // ------------------------------------------------------------
    // identification value layout
    // ------------------------------------------------------------
    localparam int ID_FIXED_POS = 0;
    localparam int ID_PROD_LSB  = 1;
    localparam int ID_PROD_W    = 11;
    localparam int ID_PART_LSB  = 12;
    localparam int ID_PART_W    = 16;
    localparam int ID_REV_LSB   = 28;
    localparam int ID_REV_W     = 4;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SHF_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SHF_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
    } bst_state_t;

    typedef enum logic [1:0] {
        CH_BOUNDARY, CH_IDENT, CH_SINGLE
    } bst_chain_t;

    // unknown codes fall back to the single-bit path
    function automatic bst_chain_t chainOf(input logic [IR_W-1:0] ir);
        case (ir)
            IR_EXTEST, IR_SAMPLE: chainOf = CH_BOUNDARY;
            IR_IDCODE:            chainOf = CH_IDENT;
            default:              chainOf = CH_SINGLE;
        endcase
    endfunction

endpackage

// file: verilog/bst_pin_sync.sv
// two-stage synchronisers for the scan pins and test-clock edge pulses
`timescale 1ns/1ps
module bst_pin_sync (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic tck,
    input  wire logic tms,
    input  wire logic tdi,
    output logic      tmsS,
    output logic      tdiS,
    output logic      tckRise,
    output logic      tckFall
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic       tckD;
    } bst_sync_t;

    bst_sync_t q_r;
    bst_sync_t q_nxt;

    // stage one feeds stage two only
    always_comb begin
        q_nxt      = q_r;
        q_nxt.s1   = {tdi, tms, tck};
        q_nxt.s2   = q_r.s1;
        q_nxt.tckD = q_r.s2[0];
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign tmsS    = q_r.s2[1];
    assign tdiS    = q_r.s2[2];
    assign tckRise = q_r.s2[0] & ~q_r.tckD;
    assign tckFall = ~q_r.s2[0] & q_r.tckD;

endmodule // bst_pin_sync

// file: verilog/bst_tap_fsm.sv
// sixteen-state test access controller stepped by test-clock rising edges
`timescale 1ns/1ps
module bst_tap_fsm (
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    input  wire logic               tckRise,
    input  wire logic               tmsS,
    output bst_pkg::bst_state_t     state
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        bst_pkg::bst_state_t st;
        logic [2:0]          ones;
    } bst_fsm_t;

    bst_fsm_t q_r;
    bst_fsm_t q_nxt;

    function automatic bst_pkg::bst_state_t step(input bst_pkg::bst_state_t s,
                                                 input logic m);
        case (s)
            bst_pkg::TLR:    step = m ? bst_pkg::TLR    : bst_pkg::RTI;
            bst_pkg::RTI:    step = m ? bst_pkg::SEL_DR : bst_pkg::RTI;
            bst_pkg::SEL_DR: step = m ? bst_pkg::SEL_IR : bst_pkg::CAP_DR;
            bst_pkg::CAP_DR: step = m ? bst_pkg::EX1_DR : bst_pkg::SHF_DR;
            bst_pkg::SHF_DR: step = m ? bst_pkg::EX1_DR : bst_pkg::SHF_DR;
            bst_pkg::EX1_DR: step = m ? bst_pkg::UPD_DR : bst_pkg::PAU_DR;
            bst_pkg::PAU_DR: step = m ? bst_pkg::EX2_DR : bst_pkg::PAU_DR;
            bst_pkg::EX2_DR: step = m ? bst_pkg::UPD_DR : bst_pkg::SHF_DR;
            bst_pkg::UPD_DR: step = m ? bst_pkg::SEL_DR : bst_pkg::RTI;
            bst_pkg::SEL_IR: step = m ? bst_pkg::TLR    : bst_pkg::CAP_IR;
            bst_pkg::CAP_IR: step = m ? bst_pkg::EX1_IR : bst_pkg::SHF_IR;
            bst_pkg::SHF_IR: step = m ? bst_pkg::EX1_IR : bst_pkg::SHF_IR;
            bst_pkg::EX1_IR: step = m ? bst_pkg::UPD_IR : bst_pkg::PAU_IR;
            bst_pkg::PAU_IR: step = m ? bst_pkg::EX2_IR : bst_pkg::PAU_IR;
            bst_pkg::EX2_IR: step = m ? bst_pkg::UPD_IR : bst_pkg::SHF_IR;
            bst_pkg::UPD_IR: step = m ? bst_pkg::SEL_DR : bst_pkg::RTI;
            default:         step = bst_pkg::TLR;
        endcase
    endfunction

    always_comb begin
        q_nxt = q_r;
        if (tckRise) begin
            q_nxt.st = step(q_r.st, tmsS);
            if (!tmsS) begin
                q_nxt.ones = 3'h0;
            end else if (q_r.ones < 3'(bst_pkg::TLR_ONES)) begin
                q_nxt.ones = q_r.ones + 3'h1;
            end
        end
    end

    // power-up lands in test-logic-reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            q_r <= '{st: bst_pkg::TLR, ones: 3'h0};
        end else begin
            q_r <= q_nxt;
        end
    end

    assign state = q_r.st;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_five_ones_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
        q_r.ones == 3'(bst_pkg::TLR_ONES) |-> q_r.st == bst_pkg::TLR)
        else $error("five high mode samples did not reach reset state");

    chk_state_on_edge: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !tckRise |=> $stable(q_r.st))
        else $error("controller moved without a test-clock rise");

    chk_shift_dr_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tckRise && q_r.st == bst_pkg::SHF_DR && !tmsS |=> q_r.st == bst_pkg::SHF_DR)
        else $error("shift-dr left with mode low");

endmodule // bst_tap_fsm

// file: verilog/bst_test_port.sv
// boundary-scan test port: instruction register, data chains and serial output
`timescale 1ns/1ps
module bst_test_port #(
    parameter logic [10:0] PRODUCER_ID = 11'h555, // value is arbitrary
    parameter logic [15:0] PART_ID     = 16'h1234, // value is arbitrary
    parameter logic [3:0]  REVISION_ID = 4'h1     // value is arbitrary
) (
    input  wire logic                      ref_clk,
    input  wire logic                      rst_n,
    input  wire logic                      tck,
    input  wire logic                      tms,
    input  wire logic                      tdi,
    output logic                           tdo,
    output logic                           tdoOe,
    input  wire logic [bst_pkg::BS_W-1:0]  pinCapture,
    input  wire logic [bst_pkg::BS_W-1:0]  coreOut,
    output logic      [bst_pkg::BS_W-1:0]  pinOut,
    output logic                           extestActive
);
    // ------------------------------------------------------------
    // identity word
    // ------------------------------------------------------------
    localparam logic [bst_pkg::ID_W-1:0] ID_VALUE = {REVISION_ID, PART_ID, PRODUCER_ID,
                                                     1'b1};

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [bst_pkg::IR_W-1:0] irShift;
        logic [bst_pkg::IR_W-1:0] irReg;
        logic [bst_pkg::BS_W-1:0] bsShift;
        logic [bst_pkg::BS_W-1:0] bsLatch;
        logic [bst_pkg::ID_W-1:0] idShift;
        logic                     singleBit;
        logic                     tdo;
        logic                     tdoOe;
        logic [bst_pkg::BS_W-1:0] pinOut;
        logic                     extest;
    } bst_core_t;

    bst_core_t           q_r;
    bst_core_t           q_nxt;
    logic                tmsS;
    logic                tdiS;
    logic                tckRise;
    logic                tckFall;
    bst_pkg::bst_state_t state;
    bst_pkg::bst_chain_t chain;
    logic                inShift;

    // ------------------------------------------------------------
    // pins and controller
    // ------------------------------------------------------------
    // the test clock is oversampled, so it must stay well below ref_clk / 4
    bst_pin_sync u_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .tck     (tck),
        .tms     (tms),
        .tdi     (tdi),
        .tmsS    (tmsS),
        .tdiS    (tdiS),
        .tckRise (tckRise),
        .tckFall (tckFall)
    );

    bst_tap_fsm u_fsm (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .tckRise (tckRise),
        .tmsS    (tmsS),
        .state   (state)
    );

    assign chain   = bst_pkg::chainOf(q_r.irReg);
    assign inShift = (state == bst_pkg::SHF_DR) || (state == bst_pkg::SHF_IR);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        q_nxt = q_r;

        if (state == bst_pkg::TLR) begin
            q_nxt.irReg = bst_pkg::IR_IDCODE;
        end

        // capture and shift act on the rise, using the pre-transition state
        if (tckRise) begin
            case (state)
                bst_pkg::CAP_DR: begin
                    case (chain)
                        bst_pkg::CH_BOUNDARY: q_nxt.bsShift = pinCapture;
                        bst_pkg::CH_IDENT:    q_nxt.idShift = ID_VALUE;
                        default:              q_nxt.singleBit = 1'b0;
                    endcase
                end
                bst_pkg::SHF_DR: begin
                    case (chain)
                        bst_pkg::CH_BOUNDARY: begin
                            q_nxt.bsShift = {tdiS, q_r.bsShift[bst_pkg::BS_W-1:1]};
                        end
                        bst_pkg::CH_IDENT: begin
                            q_nxt.idShift = {tdiS, q_r.idShift[bst_pkg::ID_W-1:1]};
                        end
                        default: begin
                            q_nxt.singleBit = tdiS;
                        end
                    endcase
                end
                bst_pkg::CAP_IR: begin
                    q_nxt.irShift = bst_pkg::IR_CAPTURE;
                end
                bst_pkg::SHF_IR: begin
                    q_nxt.irShift = {tdiS, q_r.irShift[bst_pkg::IR_W-1:1]};
                end
                default: begin
                end
            endcase
        end

        // update and serial output act on the fall
        if (tckFall) begin
            case (state)
                bst_pkg::UPD_DR: begin
                    if (chain == bst_pkg::CH_BOUNDARY) begin
                        q_nxt.bsLatch = q_r.bsShift;
                    end
                end
                bst_pkg::UPD_IR: begin
                    q_nxt.irReg = q_r.irShift;
                end
                bst_pkg::SHF_DR: begin
                    case (chain)
                        bst_pkg::CH_BOUNDARY: q_nxt.tdo = q_r.bsShift[0];
                        bst_pkg::CH_IDENT:    q_nxt.tdo = q_r.idShift[0];
                        default:              q_nxt.tdo = q_r.singleBit;
                    endcase
                end
                bst_pkg::SHF_IR: begin
                    q_nxt.tdo = q_r.irShift[0];
                end
                default: begin
                end
            endcase
            q_nxt.tdoOe = inShift;
        end

        // core keeps the pins unless external test is the live instruction
        q_nxt.extest = (q_r.irReg == bst_pkg::IR_EXTEST);
        q_nxt.pinOut = q_nxt.extest ? q_r.bsLatch : coreOut;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            q_r <= '{irReg: bst_pkg::IR_IDCODE, default: '0};
        end else begin
            q_r <= q_nxt;
        end
    end

    assign tdo          = q_r.tdo;
    assign tdoOe        = q_r.tdoOe;
    assign pinOut       = q_r.pinOut;
    assign extestActive = q_r.extest;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    logic updEvt;
    logic tdoEvt;
    assign updEvt = tckFall && (state == bst_pkg::UPD_DR) && (chain == bst_pkg::CH_BOUNDARY);
    assign tdoEvt = tckFall && inShift;

    chk_ir_reset_load: assert property (
        state == bst_pkg::TLR |=> q_r.irReg == bst_pkg::IR_IDCODE)
        else $error("reset state did not load the identification code");

    chk_ir_lsb_first: assert property (
        tckRise && state == bst_pkg::SHF_IR |=> q_r.irShift[2] == $past(tdiS)
            && q_r.irShift[1:0] == $past(q_r.irShift[2:1]))
        else $error("instruction bits not shifted lowest first");

    chk_latch_update_only: assert property (
        $changed(q_r.bsLatch) |-> $past(updEvt))
        else $error("pin latch changed outside update-dr fall");

    chk_tdo_fall_only: assert property (
        $changed(q_r.tdo) |-> $past(tdoEvt))
        else $error("serial output changed outside a shifting fall");

    chk_single_bit_delay: assert property (
        tckFall && state == bst_pkg::SHF_DR && chain == bst_pkg::CH_SINGLE
            |=> q_r.tdo == $past(q_r.singleBit))
        else $error("single-bit path did not reach serial output");

    chk_ident_capture: assert property (
        tckRise && state == bst_pkg::CAP_DR && chain == bst_pkg::CH_IDENT
            |=> q_r.idShift == ID_VALUE && q_r.idShift[0])
        else $error("identity word not captured");

    chk_pin_capture: assert property (
        tckRise && state == bst_pkg::CAP_DR && chain == bst_pkg::CH_BOUNDARY
            |=> q_r.bsShift == $past(pinCapture))
        else $error("pin chain did not capture the pins");

    chk_undef_single: assert property (
        q_r.irReg != bst_pkg::IR_EXTEST && q_r.irReg != bst_pkg::IR_SAMPLE
            && q_r.irReg != bst_pkg::IR_IDCODE |-> chain == bst_pkg::CH_SINGLE)
        else $error("undefined code did not pick the single-bit path");

    chk_extest_drive: assert property (
        q_r.irReg == bst_pkg::IR_EXTEST ##1 q_r.irReg == bst_pkg::IR_EXTEST
            |=> q_r.pinOut == $past(q_r.bsLatch))
        else $error("external test does not drive pins from the latch");

    chk_sample_core: assert property (
        q_r.irReg == bst_pkg::IR_SAMPLE |=> q_r.pinOut == $past(coreOut))
        else $error("sample broke the core-to-pin path");

    chk_ir_capture: assert property (
        tckRise && state == bst_pkg::CAP_IR
            |=> q_r.irShift == bst_pkg::IR_CAPTURE)
        else $error("instruction capture pattern not loaded");

    chk_ir_update: assert property (
        tckFall && state == bst_pkg::UPD_IR
            |=> q_r.irReg == $past(q_r.irShift))
        else $error("instruction not taken at update-ir fall");

    chk_ident_shift: assert property (
        tckRise && state == bst_pkg::SHF_DR && chain == bst_pkg::CH_IDENT
            |=> q_r.idShift == {$past(tdiS), $past(q_r.idShift[bst_pkg::ID_W-1:1])})
        else $error("identity chain did not shift toward bit zero");

    chk_ident_out: assert property (
        tckFall && state == bst_pkg::SHF_DR && chain == bst_pkg::CH_IDENT
            |=> q_r.tdo == $past(q_r.idShift[0]))
        else $error("identity bit zero not on serial output");

    chk_pin_shift: assert property (
        tckRise && state == bst_pkg::SHF_DR && chain == bst_pkg::CH_BOUNDARY
            |=> q_r.bsShift == {$past(tdiS), $past(q_r.bsShift[bst_pkg::BS_W-1:1])})
        else $error("pin chain did not shift toward bit zero");

    chk_pin_out: assert property (
        tckFall && state == bst_pkg::SHF_DR && chain == bst_pkg::CH_BOUNDARY
            |=> q_r.tdo == $past(q_r.bsShift[0]))
        else $error("pin chain bit zero not on serial output");

    chk_pin_chain_hold: assert property (
        !(tckRise && chain == bst_pkg::CH_BOUNDARY
            && (state == bst_pkg::CAP_DR || state == bst_pkg::SHF_DR))
            |=> $stable(q_r.bsShift))
        else $error("pin chain moved outside its capture or shift");

    chk_single_capture: assert property (
        tckRise && state == bst_pkg::CAP_DR && chain == bst_pkg::CH_SINGLE
            |=> !q_r.singleBit)
        else $error("single-bit path did not capture zero");

    chk_tdo_enable: assert property (
        tckFall
            |=> q_r.tdoOe == $past(inShift))
        else $error("serial output enable does not follow the shift states");

    chk_reset_core_path: assert property (
        state == bst_pkg::TLR
            |=> ##1 !q_r.extest)
        else $error("reset state left external test active");

    cov_extest_update: cover property (updEvt && q_r.irReg == bst_pkg::IR_EXTEST);
    cov_ident_shift:   cover property (tckRise && state == bst_pkg::SHF_DR
                                       && chain == bst_pkg::CH_IDENT);
    cov_single_shift:  cover property (tckRise && state == bst_pkg::SHF_DR
                                       && chain == bst_pkg::CH_SINGLE);
    cov_ir_update:     cover property (tckFall && state == bst_pkg::UPD_IR);
    cov_sample_update: cover property (updEvt && q_r.irReg == bst_pkg::IR_SAMPLE);

endmodule // bst_test_port

// file: test/bst_tap_master.sv
// model of the external scan controller driving test clock, mode select and serial data
`timescale 1ns/1ps
module bst_tap_master (
    input  wire logic ref_clk,
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo,
    input  wire logic tdoOe
);
    logic lastTdi;

    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        lastTdi = 1'b0;
    end

    // ------------------------------------------------------------
    // one test-clock period, 4 ref_clk low and 4 high; call at a ref_clk edge
    // ------------------------------------------------------------
    // mode and data move only with the clock low, so they are settled long before the rise
    task automatic step(input logic tmsV, input logic tdiV, output logic tdoV, output logic oeV);
        tms <= tmsV;
        tdi <= tdiV;
        lastTdi = tdiV;
        repeat (4) @(posedge ref_clk);
        tck <= 1'b1;
        repeat (4) @(posedge ref_clk);
        tdoV = tdo;
        oeV = tdoOe;
        tck <= 1'b0;
    endtask

    // steps without data flip the data line so a stale bit never looks valid
    task automatic move(input logic tmsV);
        logic t;
        logic o;
        step(tmsV, ~lastTdi, t, o);
    endtask

    // full scan from run-test/idle back to run-test/idle
    task automatic scan(input logic isIr, input int n, input logic [127:0] din,
                        output logic [127:0] dout, output logic oeAll);
        logic b;
        logic o;
        dout = 128'h0;
        oeAll = 1'b1;
        move(1'b1);
        if (isIr) begin
            move(1'b1);
        end
        move(1'b0);
        move(1'b0);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], b, o);
            dout[i] = b;
            oeAll = oeAll & o;
        end
        move(1'b1);
        move(1'b0);
    endtask

    // five high mode samples reach test-logic-reset from any state, then idle
    task automatic resetTap();
        repeat (5) move(1'b1);
        move(1'b0);
    endtask
endmodule // bst_tap_master

// file: test/tb_boundary_scan_test_port.sv
// self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
module tb_boundary_scan_test_port;
    localparam logic [10:0] PROD     = 11'h2a5;  // value is arbitrary
    localparam logic [15:0] PART     = 16'h0c3e; // value is arbitrary
    localparam logic [3:0]  REV      = 4'h9;     // value is arbitrary
    localparam logic [31:0] ID_EXP   = {REV, PART, PROD, 1'b1};
    localparam logic [97:0] CAP_PAT  = {49{2'h2}};
    localparam logic [97:0] CORE_PAT = {2'h3, 96'hffff_0000_a5a5_5a5a_1234_4321};
    localparam logic [97:0] B_PAT    = {2'h1, 96'h0123_4567_89ab_cdef_fedc_ba98};
    localparam logic [97:0] E_PAT    = ~B_PAT;
    localparam logic [97:0] CAP_ALT  = {49{2'h1}};
    localparam logic [97:0] CORE_ALT = ~CORE_PAT;
    localparam int          LIMIT    = 20000;

    logic         refClk     = 1'b0;
    logic         rstN       = 1'b0;
    logic [97:0]  pinCapture = 98'h0;
    logic [97:0]  coreOut    = 98'h0;
    wire logic    tck;
    wire logic    tms;
    wire logic    tdi;
    logic         tdo;
    logic         tdoOe;
    logic         extestActive;
    logic [97:0]  pinOut;
    logic [127:0] d;
    logic         oe;
    int           fails;
    int           checkCount;
    int           cycles;

    always #10 refClk = ~refClk;

    bst_test_port #(.PRODUCER_ID(PROD), .PART_ID(PART), .REVISION_ID(REV)) u_dut (
        .ref_clk(refClk), .rst_n(rstN), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdoOe(tdoOe), .pinCapture(pinCapture), .coreOut(coreOut), .pinOut(pinOut),
        .extestActive(extestActive)
    );

    bst_tap_master u_ctl (
        .ref_clk(refClk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe)
    );

    // ------------------------------------------------------------
    // comparison and closing
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        checkCount++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d, mismatches %0d", checkCount, fails);
        if (fails == 0 && checkCount > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // a hung controller would leave the run spinning forever
    always @(posedge refClk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fails++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic loadIr(input logic [2:0] code);
        u_ctl.scan(1'b1, 3, {125'h0, code}, d, oe);
    endtask

    // single-bit path: first bit out is the captured zero, then input delayed by one
    task automatic byp(input int n, input logic [127:0] din);
        logic [127:0] exp;
        exp = (din << 1) & ((128'h1 << n) - 128'h1);
        u_ctl.scan(1'b0, n, din, d, oe);
        check("bypass path", d, exp);
    endtask

    task automatic t_idAfterReset();
        repeat (4) @(posedge refClk);
        check("extest flag at reset", extestActive, 1'b0);
        check("tdoOe idle", tdoOe, 1'b0);
        check("pinOut at reset", pinOut, coreOut);
        u_ctl.resetTap();
        u_ctl.scan(1'b0, 32, 128'h0, d, oe);
        check("ident value", d[31:0], ID_EXP);
        check("tdoOe in shift", oe, 1'b1);
    endtask

    task automatic t_irCaptureBypass();
        u_ctl.scan(1'b1, 3, {125'h0, bst_pkg::IR_BYPASS}, d, oe);
        check("ir capture", d[2:0], bst_pkg::IR_CAPTURE);
        byp(9, 128'h1b5);
    endtask

    // 011 and 001 catch a reversed shift order against 110 and 100
    task automatic t_undefinedCodes();
        logic [2:0] codes [4] = '{3'h1, 3'h2, 3'h3, 3'h5};
        foreach (codes[k]) begin
            loadIr(codes[k]);
            byp(6, 128'h2d);
        end
    endtask

    task automatic t_sample();
        loadIr(bst_pkg::IR_SAMPLE);
        u_ctl.scan(1'b0, bst_pkg::BS_W, {30'h0, B_PAT}, d, oe);
        check("sample capture", d[97:0], pinCapture);
        check("sample core path", pinOut, coreOut);
        check("sample extest flag", extestActive, 1'b0);
        coreOut <= CORE_ALT;
        repeat (4) @(posedge refClk);
        check("sample core follows", pinOut, CORE_ALT);
    endtask

    task automatic t_extest();
        loadIr(bst_pkg::IR_EXTEST);
        check("extest flag", extestActive, 1'b1);
        check("preload drive", pinOut, B_PAT);
        pinCapture <= CAP_ALT;
        u_ctl.scan(1'b0, bst_pkg::BS_W, {30'h0, E_PAT}, d, oe);
        check("extest capture", d[97:0], CAP_ALT);
        repeat (4) @(posedge refClk);
        check("extest drive", pinOut, E_PAT);
    endtask

    // four high samples from shift must not reset, the fifth must
    task automatic t_tmsReset();
        u_ctl.move(1'b1);
        u_ctl.move(1'b0);
        u_ctl.move(1'b0);
        repeat (3) u_ctl.move(1'b0);
        check("latch held in shift", pinOut, E_PAT);
        repeat (4) u_ctl.move(1'b1);
        check("four high samples", extestActive, 1'b1);
        u_ctl.move(1'b1);
        repeat (8) @(posedge refClk);
        check("reset extest flag", extestActive, 1'b0);
        check("reset core path", pinOut, coreOut);
        u_ctl.move(1'b0);
        u_ctl.scan(1'b0, 32, 128'h0, d, oe);
        check("ident after reset", d[31:0], ID_EXP);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge refClk);
        rstN <= 1'b1;
        pinCapture <= CAP_PAT;
        coreOut <= CORE_PAT;
        @(posedge refClk);
        t_idAfterReset();
        t_irCaptureBypass();
        t_undefinedCodes();
        t_sample();
        t_extest();
        t_tmsReset();
        conclude();
    end
endmodule // tb_boundary_scan_test_port
